// ===== bench/efc_properties.sv
// Purpose: Checker for efc_function_config_regs
// Assumes: No sideband load near reads
// Notes: Bound at file foot
`timescale 1ns/10ps
module efc_properties (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input efc_pkg::efc_ctrl_t ctrl
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd60;
  logic rd68;
  assign rd60 = pready && !pwrite && paddr == 12'h060;
  assign rd68 = pready && !pwrite && paddr == 12'h068;
  rdy_setup_a: assert property (psel && !penable |=> pready) else $error("late");
  rdy_pulse_a: assert property (pready |=> !pready) else $error("held");
  no_err_a: assert property (!pslverr) else $error("error");
  cap_id_a: assert property (pready && !pwrite && paddr == 12'h080 |-> prdata == 32'h1)
    else $error("id");
  sof_len_a: assert property (rd60 |=> ctrl.sof_period ==
    16'he860 + {6'h0, $past(prdata[13:8]), 4'h0}) else $error("sof");
  wake_map_a: assert property (rd60 |=> ctrl.port_wake == $past(prdata[20:16]))
    else $error("wake");
  res_zero_a: assert property (rd60 |-> prdata[31:21] == 0 && prdata[15:14] == 0)
    else $error("res");
  misc_out_a: assert property (rd68 |=> ctrl.prefetch_en == $past(prdata[2]))
    else $error("misc");
endmodule // efc_properties
bind efc_function_config_regs efc_properties efc_properties_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ctrl(ctrl));

// ===== bench/tb.sv
// Purpose: Directed APB tests of the config bank
// Assumes: Writes may set reserved bits and encodings
// Notes: Two idle edges after each access
`timescale 1ns/10ps
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic load_valid = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [15:0] load_misc = 0;
  efc_pkg::efc_ctrl_t ctrl;
  int n_errors = 0, check_count = 0;
  efc_function_config_regs efc_function_config_regs_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .load_valid(load_valid), .load_misc(load_misc), .ctrl(ctrl));
  initial forever #5 pclk = ~pclk;
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
    end
    q = prdata;
    psel <= 0;
    penable <= 0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    ap(0, a, 0);
    chk($sformatf("reg %h", a), q, e);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rc(12'h060, 32'h000f2020);
    rc(12'h068, 32'h9000);
    rc(12'h070, 32'h0);
    $display("reset test done");
    ap(1, 12'h060, 32'hffffffff);
    ap(1, 12'h080, 32'hffffffff);
    rc(12'h060, 32'h001f3f20);
    rc(12'h080, 32'h1);
    chk("sof", ctrl.sof_period, 32'd60496);
    ap(1, 12'h068, 32'h7f17);
    rc(12'h068, 32'hff17);
    chk("rrs", ctrl.rrs_sel, 32'h2);
    chk("pf", {ctrl.single_ctrl, ctrl.prefetch_en, ctrl.prefetch_word_count}, 32'h1ff);
    ap(1, 12'h068, 32'hff);
    rc(12'h068, 32'h8077);
    ap(1, 12'h068, 32'h2);
    chk("lim", ctrl.rrs_sel, 32'h1);
    ap(1, 12'h068, 32'h0);
    chk("nrm", {ctrl.single_ctrl, ctrl.rrs_sel}, 32'h3);
    $display("write test done");
    load_misc <= 16'h0a15;
    load_valid <= 1;
    @(posedge pclk);
    load_valid <= 0;
    @(posedge pclk);
    rc(12'h068, 32'h8a15);
    $display("load test done");
    summarize();
  end
  initial begin
    #20000;
    n_errors++;
    summarize();
  end
endmodule // tb

// ===== verilog/efc_function_config_regs.sv
// Purpose: APB register bank for EHCI micro-frame, wake mask and misc control
// Assumes: Sideband load is a one-cycle strobe from the loader on pclk
// Notes: Unmapped addresses read zero, writes ignored, no slave error
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`include "efc_params.svh"
module efc_function_config_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic load_valid,
  input wire logic [15:0] load_misc,
  output efc_pkg::efc_ctrl_t ctrl
);
  logic [5:0] fladj;
  logic [5:0] next_fladj;
  logic [4:0] wake;
  logic [4:0] next_wake;
  efc_pkg::efc_misc_t misc;
  efc_pkg::efc_misc_t next_misc;
  logic [31:0] next_prdata;
  logic next_pready;
  efc_pkg::efc_ctrl_t next_ctrl;
  logic setup;
  logic wr;

  function automatic logic [31:0] rd_word(input logic [11:0] a, input logic [5:0] f,
                                          input logic [4:0] w, input logic [15:0] m);
    logic [31:0] r;
    r = 32'h0;
    unique case (a)
      `EFC_OFF_FRAME: r = {11'h000, w, 2'h0, f, `EFC_SBRN_VAL};
      `EFC_OFF_MISC: r = {16'h0000, m};
      `EFC_OFF_PMCAP: r = {24'h000000, `EFC_CAP_ID};
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  // Read taken in setup cycle, answered next cycle with pready; write taken in that pready cycle
  assign setup = psel && !penable;
  assign wr = psel && penable && pready && pwrite;

  always_comb begin
    next_fladj = fladj;
    next_wake = wake;
    next_misc = misc;
    if (wr && paddr == `EFC_OFF_FRAME) begin
      if (pstrb[1]) begin
        next_fladj = pwdata[13:8];
      end
      if (pstrb[2]) begin
        next_wake = pwdata[20:16];
      end
    end
    if (wr && paddr == `EFC_OFF_MISC) begin
      if (pstrb[0]) begin
        // Bits 3 and 7 stay clear whatever is written
        next_misc[7:0] = pwdata[7:0] & 8'(`EFC_MISC_RW_MASK);
      end
      if (pstrb[1]) begin
        next_misc[15:8] = (pwdata[15:8] & 8'(`EFC_MISC_RW_MASK >> 8))
                          | 8'(`EFC_MISC_R15 >> 8);
      end
    end
    // Loader replaces defaults; it wins over a same-cycle bus write
    if (load_valid) begin
      next_misc = (load_misc & `EFC_MISC_RW_MASK) | `EFC_MISC_R15;
    end
  end

  always_comb begin
    next_pready = setup;
    next_prdata = prdata;
    if (setup) begin
      next_prdata = pwrite ? 32'h0 : rd_word(paddr, fladj, wake, misc);
    end
  end

  always_comb begin
    next_ctrl.single_ctrl = misc.single_ctrl;
    next_ctrl.prefetch_en = misc.prefetch_en;
    next_ctrl.prefetch_word_count = misc.prefetch_word_count;
    next_ctrl.port_wake = wake;
    // User enable wins over the 64-byte limit; every user code, user_rrs ignored, selects 128
    if (misc.user_rrs_en) begin
      next_ctrl.rrs_sel = `EFC_RRS_128;
    end else if (misc.limit_64) begin
      next_ctrl.rrs_sel = `EFC_RRS_64;
    end else begin
      next_ctrl.rrs_sel = `EFC_RRS_DFLT;
    end
    next_ctrl.sof_period = `EFC_SOF_BASE + (16'(fladj) * `EFC_STEP_BITS);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fladj <= `EFC_FLADJ_RST;
      wake <= `EFC_WAKE_RST;
      misc <= `EFC_MISC_RST;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ctrl <= '0;
    end else begin
      fladj <= next_fladj;
      wake <= next_wake;
      misc <= next_misc;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= 1'b0;
      ctrl <= next_ctrl;
    end
  end
endmodule // efc_function_config_regs

// ===== verilog/efc_params.svh
// Purpose: Offsets, fields, reset values and timing counts of the EHCI function config bank
// Assumes: APB byte addresses, 32-bit aligned words
// Notes: Words 0x60 and 0x68 hold several fields each
`ifndef EFC_PARAMS_SVH
`define EFC_PARAMS_SVH
`define EFC_OFF_FRAME 12'h060
`define EFC_OFF_MISC 12'h068
`define EFC_OFF_PMCAP 12'h080
`define EFC_SBRN_VAL 8'h20
`define EFC_FLADJ_RST 6'h20
`define EFC_WAKE_RST 5'h0f
`define EFC_MISC_RST 16'h9000
`define EFC_CAP_ID 8'h01
`define EFC_SOF_BASE 16'he860
`define EFC_STEP_BITS 16'h0010
`define EFC_RRS_64 2'h1
`define EFC_RRS_128 2'h2
`define EFC_RRS_DFLT 2'h3
`define EFC_MISC_RW_MASK 16'h7f77
`define EFC_MISC_R15 16'h8000
`endif

// ===== verilog/efc_pkg.sv
// Purpose: Types of the EHCI function config bank
// Assumes: Nothing beyond the params header
// Notes: Misc control packed as laid out in its word
package efc_pkg;
  typedef struct packed {
    logic res15;
    logic [6:0] prefetch_word_count;
    logic res7;
    logic [1:0] user_rrs;
    logic user_rrs_en;
    logic res3;
    logic prefetch_en;
    logic limit_64;
    logic single_ctrl;
  } efc_misc_t;
  typedef struct packed {
    logic single_ctrl;
    logic prefetch_en;
    logic [6:0] prefetch_word_count;
    logic [1:0] rrs_sel;
    logic [15:0] sof_period;
    logic [4:0] port_wake;
  } efc_ctrl_t;
endpackage
